/* File: eqs_egress_sched.sv */
/*
  Egress queue scheduler, leaky-bucket limiter and VLAN tag editor for
  three transmit ports. Assumes the buffer manager and the MACs run on
  clk, the buffer answers a read request with one descriptor, and each
  MAC pulses tx_done when it has sent the frame it was given.
*/
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/1ps

// How it works
// - pending queues are read and sent
// - fixed mode serves queue 3 down to 0
// - otherwise weighted round-robin 9:4:2:1
// - weighted slots interleave queues, not bursts
// - per-queue leaky bucket, enabled per queue
// - limited packets wait in buffer memory
// - limiter masks queues before selection
// - hold queue for length times byte time
// - byte time 20 ns times setting+1, min 80
// - 10 Mbps port above 39 is unlimited
// - dumb port strips only special tags
// - access port strips every tag
// - cpu port adds the special tag
// - untag bit picked by ingress port
// - hybrid untagged gets tag if allowed
// - hybrid priority tag stripped or re-vided
// - hybrid normal tag stripped, modified or passed
// - hybrid modify uses ingress defaults for priority tags, egress for normal
// - four frame kinds, four port kinds
// - four virtual queues per transmit port
// - special tag VID holds source port
// - regular tag kept behind special tag
module eqs_egress_sched
  import eqs_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  input  wire logic [NQ_ALL-1:0] q_pend,
  output logic                   rd_req,
  output logic      [1:0]        rd_port,
  output logic      [1:0]        rd_queue,
  input  wire logic              desc_valid,
  input  wire eqs_desc_t         desc,
  output logic                   tx_valid,
  output logic      [1:0]        tx_port,
  output eqs_tx_t                tx_desc,
  input  wire logic [NPORT-1:0]  tx_done
);

  typedef enum logic [1:0] {ST_SCAN, ST_WAIT} eqs_state_t;

  function automatic logic [1:0] top_q(input logic [3:0] m);
    if (m[3]) return 2'd3;
    if (m[2]) return 2'd2;
    if (m[1]) return 2'd1;
    return 2'd0;
  endfunction

  // cycles a queue stays closed after a frame of len bytes
  function automatic logic [31:0] hold_cyc(input logic [10:0] len,
                                           input logic [12:0] set);
    logic [12:0] eff;
    eff = (set < MIN_SET) ? MIN_SET : set;
    return 32'(len) * (32'(eff) + 32'd1) * 32'(CYC_PER_STEP);
  endfunction

  function automatic logic [1:0] nxt_port(input logic [1:0] p);
    return (p == 2'(NPORT - 1)) ? 2'd0 : p + 2'd1;
  endfunction

  logic              fixed_r;
  logic [23:0]       kind_r;
  logic [14:0]       def_r [NPORT];
  logic [NQ_ALL-1:0] rate_en_r;
  logic [NPORT-1:0]  spd10_r;
  logic [12:0]       rate_set_r [NQ_ALL];
  logic [NQ_ALL-1:0] lim_r;
  logic [31:0]       tmr_r [NQ_ALL];
  logic [NPORT-1:0]  busy_r;
  logic [3:0]        slot_r [NPORT];
  logic [1:0]        p_r;
  eqs_state_t        st_r;
  logic [31:0]       rdata_nxt;
  eqs_tx_t           edit_nxt;

  // register decode
  wire [7:0] def_off  = reg_addr - OFS_DEF0;
  wire       def_hit  = reg_addr >= OFS_DEF0 && reg_addr < OFS_DEF_END
                        && def_off[1:0] == 2'b00;
  wire [1:0] def_idx  = def_off[3:2];
  wire [7:0] rate_off = reg_addr - OFS_RATE0;
  wire       rate_hit = reg_addr >= OFS_RATE0 && reg_addr < OFS_RATE_END
                        && rate_off[1:0] == 2'b00;
  wire [3:0] rate_idx = rate_off[5:2];
  wire       wr_cfg   = reg_wr && reg_addr == OFS_CFG;
  wire       wr_kind  = reg_wr && reg_addr == OFS_KIND;
  wire       wr_def   = reg_wr && def_hit;
  wire       wr_ren   = reg_wr && reg_addr == OFS_RATE_EN;
  wire       wr_rate  = reg_wr && rate_hit;

  always_comb begin
    rdata_nxt = 32'h00000000;
    if (reg_addr == OFS_CFG)
      rdata_nxt[CFG_FIXED] = fixed_r;
    else if (reg_addr == OFS_KIND)
      rdata_nxt = {8'h00, kind_r};
    else if (def_hit)
      rdata_nxt = {17'h00000, def_r[def_idx]};
    else if (reg_addr == OFS_RATE_EN)
      rdata_nxt = {13'h0000, spd10_r, 4'h0, rate_en_r};
    else if (reg_addr == OFS_STATUS)
      rdata_nxt = {17'h00000, busy_r, lim_r};
    else if (rate_hit)
      rdata_nxt = {19'h00000, rate_set_r[rate_idx]};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fixed_r   <= 1'b0;
      kind_r    <= KIND_RST;
      rate_en_r <= '0;
      spd10_r   <= '0;
      for (int i = 0; i < NPORT; i++) begin
        def_r[i] <= DEF_RST;
      end
      for (int i = 0; i < NQ_ALL; i++) begin
        rate_set_r[i] <= 13'h0000;
      end
    end else begin
      if (wr_cfg)
        fixed_r <= reg_wdata[CFG_FIXED];
      if (wr_kind)
        kind_r <= reg_wdata[23:0];
      if (wr_def)
        def_r[def_idx] <= reg_wdata[14:0];
      if (wr_ren) begin
        rate_en_r <= reg_wdata[NQ_ALL-1:0];
        spd10_r   <= reg_wdata[SPD10_LSB +: NPORT];
      end
      if (wr_rate)
        rate_set_r[rate_idx] <= reg_wdata[12:0];
    end
  end

  // selection for the port under scan
  wire [3:0] base    = {p_r, 2'b00};
  wire [3:0] pend    = q_pend[base +: NQ];
  wire [3:0] elig    = pend & ~lim_r[base +: NQ];
  wire [1:0] slot_q  = WRR_SEQ[{slot_r[p_r], 1'b0} +: 2];
  wire [1:0] pick    = fixed_r ? top_q(elig)
                     : (elig[slot_q] ? slot_q : top_q(elig));
  wire       grant   = st_r == ST_SCAN && !busy_r[p_r] && |elig;
  wire [3:0] gq      = {rd_port, rd_queue};

  // limiter bypass: disabled, or slow port with a huge setting
  wire [NQ_ALL-1:0] bypass;
  for (genvar i = 0; i < NQ_ALL; i++) begin : g_byp
    assign bypass[i] = !rate_en_r[i] ||
                       (spd10_r[i/NQ]
                        && rate_set_r[i] > SLOW_MAX_SET);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r     <= ST_SCAN;
      p_r      <= 2'd0;
      rd_req   <= 1'b0;
      rd_port  <= 2'd0;
      rd_queue <= 2'd0;
      for (int i = 0; i < NPORT; i++) begin
        slot_r[i] <= 4'h0;
      end
    end else begin
      rd_req <= 1'b0;
      case (st_r)
        ST_SCAN: begin
          if (grant) begin
            rd_req   <= 1'b1;
            rd_port  <= p_r;
            rd_queue <= pick;
            if (!fixed_r)
              slot_r[p_r] <= slot_r[p_r] + 4'h1;
            st_r <= ST_WAIT;
          end else begin
            p_r <= nxt_port(p_r);
          end
        end
        ST_WAIT: begin
          if (desc_valid) begin
            p_r  <= nxt_port(p_r);
            st_r <= ST_SCAN;
          end
        end
        default: st_r <= ST_SCAN;
      endcase
    end
  end

  // leaky bucket: closed at grant, reloaded once the length is known
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lim_r <= '0;
      for (int i = 0; i < NQ_ALL; i++) begin
        tmr_r[i] <= 32'h00000000;
      end
    end else begin
      for (int i = 0; i < NQ_ALL; i++) begin
        if (grant && 4'(i) == {p_r, pick} && !bypass[i]) begin
          lim_r[i] <= 1'b1;
          tmr_r[i] <= 32'hFFFFFFFF;
        end else if (desc_valid && st_r == ST_WAIT && 4'(i) == gq
                     && lim_r[i]) begin
          tmr_r[i] <= hold_cyc(desc.len, rate_set_r[i]);
        end else if (lim_r[i]) begin
          // a rate change mid-hold is honoured on the next frame; a bypass ends the hold at once
          if (tmr_r[i] <= 32'h00000001 || bypass[i])
            lim_r[i] <= 1'b0;
          tmr_r[i] <= tmr_r[i] - 32'h00000001;
        end
      end
    end
  end

  // tag editing for the descriptor now arriving
  wire [5:0]     kcfg    = kind_r[rd_port * KIND_STRIDE +: 6];
  wire [1:0]     kind_pk = kcfg[1:0];
  wire [1:0]     inp     = desc.in_port;
  wire [1:0]     inp_ok  = (inp < 2'(NPORT)) ? inp : 2'd0;
  wire           ut      = desc.untag[inp_ok];
  wire [14:0]    def_in  = def_r[inp_ok];
  wire [14:0]    def_out = def_r[rd_port];
  wire           chg_vid = kcfg[KF_CHG_VID];
  wire           chg_pri = kcfg[KF_CHG_PRI];

  always_comb begin
    edit_nxt     = '0;
    edit_nxt.act = ACT_PASS;
    edit_nxt.vid = desc.vid;
    edit_nxt.pri = desc.pri;
    case (kind_pk)
      PK_DUMB: begin
        if (desc.kind == RX_SPECIAL)
          edit_nxt.act = ACT_STRIP;
      end
      PK_ACCESS: begin
        if (desc.kind != RX_NONE)
          edit_nxt.act = ACT_STRIP;
      end
      PK_CPU: begin
        // an existing normal tag stays, behind the new one
        edit_nxt.act = ACT_SPECIAL;
        edit_nxt.vid = {10'h000, inp_ok};
      end
      PK_HYBRID: begin
        case (desc.kind)
          RX_NONE: begin
            if (kcfg[KF_INS] && !ut) begin
              edit_nxt.act = ACT_INSERT;
              edit_nxt.vid = def_in[11:0];
              edit_nxt.pri = def_in[DEF_PRI_LSB +: 3];
            end
          end
          RX_PRIO: begin
            if (ut) begin
              edit_nxt.act = ACT_STRIP;
            end else begin
              edit_nxt.act = ACT_MODIFY;
              edit_nxt.vid = def_in[11:0];
              if (chg_pri)
                edit_nxt.pri = def_in[DEF_PRI_LSB +: 3];
            end
          end
          RX_NORMAL: begin
            if (ut) begin
              edit_nxt.act = ACT_STRIP;
            end else if (kcfg[KF_CHG_TAG] && (chg_vid || chg_pri)) begin
              edit_nxt.act = ACT_MODIFY;
              if (chg_vid)
                edit_nxt.vid = def_out[11:0];
              if (chg_pri)
                edit_nxt.pri = def_out[DEF_PRI_LSB +: 3];
            end
          end
          default: edit_nxt.act = ACT_STRIP;
        endcase
      end
      default: edit_nxt.act = ACT_PASS;
    endcase
    // new length and fresh FCS whenever bytes change
    edit_nxt.len = {1'b0, desc.len};
    if (edit_nxt.act == ACT_STRIP)
      edit_nxt.len = {1'b0, desc.len} - TAG_BYTES;
    else if (edit_nxt.act == ACT_INSERT)
      edit_nxt.len = {1'b0, desc.len} + TAG_BYTES;
    else if (edit_nxt.act == ACT_SPECIAL && desc.kind != RX_SPECIAL)
      edit_nxt.len = {1'b0, desc.len} + TAG_BYTES;
    edit_nxt.fcs_regen = edit_nxt.act != ACT_PASS;
  end

  // hand-off to the MAC; a port stays busy until its frame is sent
  wire take = desc_valid && st_r == ST_WAIT;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_valid <= 1'b0;
      tx_port  <= 2'd0;
      tx_desc  <= '0;
      busy_r   <= '0;
    end else begin
      tx_valid <= take;
      if (take) begin
        tx_port <= rd_port;
        tx_desc <= edit_nxt;
      end
      for (int i = 0; i < NPORT; i++) begin
        if (take && rd_port == 2'(i))
          busy_r[i] <= 1'b1;
        else if (tx_done[i])
          busy_r[i] <= 1'b0;
      end
    end
  end

endmodule

/* File: eqs_egress_sched_assertions.sv */
/*
  Port checks of the egress scheduler, bound to every instance.
  Assumes the buffer sends a descriptor only for a real read.
*/
`timescale 1ns/1ps
module eqs_egress_sched_assertions
  import eqs_pkg::*;
(
  input wire logic             clk,
  input wire logic             rst_n,
  input wire logic             rd_req,
  input wire logic [1:0]       rd_port,
  input wire logic             desc_valid,
  input wire eqs_desc_t        desc,
  input wire logic             tx_valid,
  input wire logic [1:0]       tx_port,
  input wire eqs_tx_t          tx_desc,
  input wire logic [NPORT-1:0] tx_done
);
  logic             out_r;
  logic [NPORT-1:0] busy_r;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // shadow handshakes: open read and ports with a frame in flight
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_r  <= 1'b0;
      busy_r <= '0;
    end else begin
      out_r  <= rd_req | (out_r & ~desc_valid);
      busy_r <= (busy_r & ~tx_done) | (tx_valid ? 3'h1 << tx_port : 3'h0);
    end
  end

  AST_RD_PULSE: assert property (rd_req |=> !rd_req)
    else $error("read request longer than one cycle");
  AST_ONE_READ: assert property (rd_req |-> !out_r)
    else $error("second read before descriptor");
  AST_DESC_TX: assert property (
    desc_valid |=> tx_valid && tx_port == $past(rd_port))
    else $error("frame not handed on after descriptor");
  AST_PORT_FREE: assert property (tx_valid |-> !busy_r[tx_port])
    else $error("frame sent to busy port");
  AST_FCS: assert property (
    tx_valid |-> tx_desc.fcs_regen == (tx_desc.act != ACT_PASS))
    else $error("fcs flag wrong");
  AST_LEN_KEEP: assert property (
    tx_valid && tx_desc.act inside {ACT_PASS, ACT_MODIFY}
    |-> tx_desc.len == {1'b0, $past(desc.len)})
    else $error("length changed without tag change");
  AST_LEN_CUT: assert property (
    tx_valid && tx_desc.act == ACT_STRIP
    |-> tx_desc.len == {1'b0, $past(desc.len)} - TAG_BYTES)
    else $error("strip length wrong");
  AST_LEN_ADD: assert property (
    tx_valid && tx_desc.act == ACT_INSERT
    |-> tx_desc.len == {1'b0, $past(desc.len)} + TAG_BYTES)
    else $error("insert length wrong");
  AST_SRC_PORT: assert property (
    tx_valid && tx_desc.act == ACT_SPECIAL |-> tx_desc.vid[1:0] ==
    ($past(desc.in_port) == 2'h3 ? 2'h0 : $past(desc.in_port)))
    else $error("special tag source port wrong");
endmodule

bind eqs_egress_sched eqs_egress_sched_assertions
  u_eqs_egress_sched_assertions (.clk, .rst_n, .rd_req, .rd_port,
  .desc_valid, .desc, .tx_valid, .tx_port, .tx_desc, .tx_done);

/* File: eqs_mac_model.sv */
/*
  Buffer and transmit MAC stand-in for the egress scheduler.
  Assumes the bench supplies the descriptor and the MAC latency.
*/
`timescale 1ns/1ps
module eqs_mac_model
  import eqs_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             rd_req,
  input  wire eqs_desc_t        next_desc,
  input  wire logic [3:0]       lat,
  input  wire logic             tx_valid,
  input  wire logic [1:0]       tx_port,
  output logic                  desc_valid,
  output eqs_desc_t             desc,
  output logic      [NPORT-1:0] tx_done
);
  logic [3:0] cnt_r [NPORT];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      desc_valid <= 1'b0;
      desc       <= '0;
      tx_done    <= '0;
      for (int p = 0; p < NPORT; p++) cnt_r[p] <= 4'h0;
    end else begin
      desc_valid <= rd_req;
      // junk between replies so a stale descriptor is never reused
      desc       <= rd_req ? next_desc : ~desc;
      for (int p = 0; p < NPORT; p++) begin
        tx_done[p] <= (cnt_r[p] == 4'h1);
        if (tx_valid && tx_port == 2'(p))
          cnt_r[p] <= lat;
        else if (cnt_r[p] != 4'h0)
          cnt_r[p] <= cnt_r[p] - 4'h1;
      end
    end
  end
endmodule

/* File: eqs_pkg.sv */
/*
  Constants, register map and carrier types of the egress queue scheduler
  and tag editor. Assumes one switch core clock of 250 MHz.
*/
package eqs_pkg;
  localparam int NPORT  = 3;
  localparam int NQ     = 4;
  localparam int NQ_ALL = NPORT * NQ;

  // register byte offsets
  localparam logic [7:0] OFS_CFG     = 8'h00;
  localparam logic [7:0] OFS_KIND    = 8'h04;
  localparam logic [7:0] OFS_DEF0    = 8'h08;
  localparam logic [7:0] OFS_DEF_END = 8'h14;
  localparam logic [7:0] OFS_RATE_EN = 8'h14;
  localparam logic [7:0] OFS_STATUS  = 8'h18;
  localparam logic [7:0] OFS_RATE0   = 8'h20;
  localparam logic [7:0] OFS_RATE_END = 8'h50;

  // field positions
  localparam int CFG_FIXED   = 0;
  localparam int KIND_STRIDE = 8;
  localparam int KF_INS      = 2;
  localparam int KF_CHG_TAG  = 3;
  localparam int KF_CHG_VID  = 4;
  localparam int KF_CHG_PRI  = 5;
  localparam int DEF_PRI_LSB = 12;
  localparam int SPD10_LSB   = 16;
  localparam int ST_BUSY_LSB = 12;

  // reset values
  localparam logic [23:0] KIND_RST = 24'h000000;
  localparam logic [14:0] DEF_RST  = 15'h0001;

  // weighted order 9:4:2:1, two bits a slot, slot 0 lowest
  localparam logic [31:0] WRR_SEQ = 32'hFB7B3B7B;

  // leaky bucket timing
  localparam int          CLK_NS       = 4;
  localparam int          NS_PER_STEP  = 20;
  localparam int          CYC_PER_STEP = NS_PER_STEP / CLK_NS;
  localparam logic [12:0] MIN_SET      = 13'h0003;
  localparam logic [12:0] SLOW_MAX_SET = 13'h0027;
  localparam logic [11:0] TAG_BYTES    = 12'h004;

  typedef enum logic [1:0] {
    PK_DUMB   = 2'b00,
    PK_ACCESS = 2'b01,
    PK_HYBRID = 2'b10,
    PK_CPU    = 2'b11
  } eqs_port_kind_t;

  typedef enum logic [1:0] {
    RX_NONE, RX_PRIO, RX_NORMAL, RX_SPECIAL
  } eqs_rx_kind_t;

  typedef enum logic [2:0] {
    ACT_PASS, ACT_STRIP, ACT_INSERT, ACT_MODIFY, ACT_SPECIAL
  } eqs_tag_act_t;

  typedef struct packed {
    logic [10:0]  len;
    eqs_rx_kind_t kind;
    logic [1:0]   in_port;
    logic [11:0]  vid;
    logic [2:0]   pri;
    logic [2:0]   untag;
  } eqs_desc_t;

  typedef struct packed {
    eqs_tag_act_t act;
    logic [11:0]  vid;
    logic [2:0]   pri;
    logic [11:0]  len;
    logic         fcs_regen;
  } eqs_tx_t;
endpackage

/* File: eqs_tb.sv */
/*
  Self-checking bench of the egress scheduler.
  Assumes the mac model answers every read and every frame.
*/
`timescale 1ns/1ps
module testbench
  import eqs_pkg::*;
;
  logic              clk;
  logic              rst_n;
  logic [7:0]        reg_addr;
  logic [31:0]       reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [31:0]       reg_rdata;
  logic [NQ_ALL-1:0] q_pend;
  logic              rd_req;
  logic [1:0]        rd_port;
  logic [1:0]        rd_queue;
  logic              desc_valid;
  eqs_desc_t         desc;
  eqs_desc_t         bdesc;
  logic              tx_valid;
  logic [1:0]        tx_port;
  eqs_tx_t           tx_desc;
  logic [NPORT-1:0]  tx_done;
  logic [3:0]        lat;
  logic [31:0]       rv;
  int                error_cnt;
  int                cmp_count;
  int                cyc;
  int                t0;

  eqs_egress_sched u_eqs_egress_sched (.clk, .rst_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .q_pend, .rd_req, .rd_port, .rd_queue,
    .desc_valid, .desc, .tx_valid, .tx_port, .tx_desc, .tx_done);
  eqs_mac_model u_eqs_mac_model (.clk, .rst_n, .rd_req, .next_desc(bdesc),
    .lat, .tx_valid, .tx_port, .desc_valid, .desc, .tx_done);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) cyc++;

  task automatic chk(input logic [31:0] s, input logic [31:0] e,
      input string what);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // wait is bounded above the longest limiter hold used here
  task automatic grant(input logic [3:0] e);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (rd_req !== 1'b1 && n < 3000);
    chk(rd_req, 1'b1, "read seen");
    chk({rd_port, rd_queue}, e, "grant");
  endtask
  task automatic tc(input logic [7:0] kb, input eqs_rx_kind_t rk,
      input logic [2:0] ut, input eqs_tag_act_t ea, input logic [11:0] ev,
      input logic [2:0] ep, input logic [11:0] el);
    int n;
    wr(OFS_KIND, {24'h000000, kb});
    bdesc     <= '{11'h064, rk, 2'h1, 12'h0AB, 3'h2, ut};
    q_pend[0] <= 1'b1;
    grant(4'h0);
    @(posedge clk);
    q_pend[0] <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (tx_valid !== 1'b1 && n < 50);
    chk(tx_valid, 1'b1, "tx seen");
    chk(tx_port, 2'h0, "tx port");
    chk(tx_desc.fcs_regen, ea != ACT_PASS, "fcs");
    chk(tx_desc.act, ea, "act");
    chk(tx_desc.len, el, "len");
    if (ea == ACT_INSERT || ea == ACT_MODIFY)
      chk({tx_desc.vid, tx_desc.pri}, {ev, ep}, "tag");
    if (ea == ACT_SPECIAL)
      chk(tx_desc.vid[1:0], 2'h1, "src");
  endtask
  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    final_report;
  end

  initial begin
    rst_n     = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    q_pend    = '0;
    bdesc     = '0;
    lat       = 4'h3;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(OFS_KIND, rv);
    chk(rv, {8'h00, KIND_RST}, "kind");
    rd(OFS_DEF0, rv);
    chk(rv, {17'h0, DEF_RST}, "def0");
    rd(8'hFC, rv);
    chk(rv, 32'h0, "unmapped");
    wr(OFS_DEF0, 32'h00003456);
    wr(OFS_DEF0 + 8'h04, 32'h00005123);
    rd(OFS_DEF0 + 8'h04, rv);
    chk(rv, 32'h00005123, "def1");
    $display("test regs done");
    @(posedge clk);
    q_pend <= 12'h0F0;
    for (int i = 0; i < 16; i++)
      grant({2'h1, WRR_SEQ[2*i +: 2]});
    @(posedge clk);
    q_pend <= 12'h000;
    wr(OFS_CFG, 32'h1);
    q_pend <= 12'h0F0;
    for (int i = 0; i < 4; i++) begin
      grant({2'h1, 2'(3 - i)});
      @(posedge clk);
      q_pend[7 - i] <= 1'b0;
    end
    $display("test sched done");
    lat <= 4'hC;
    // port 0 is the only one ever given the cpu kind
    tc(8'h00,RX_NORMAL,3'h0,ACT_PASS,12'h000,3'h0,12'h064);
    tc(8'h00,RX_SPECIAL,3'h0,ACT_STRIP,12'h000,3'h0,12'h060);
    tc(8'h01,RX_PRIO,3'h0,ACT_STRIP,12'h000,3'h0,12'h060);
    tc(8'h03,RX_NORMAL,3'h0,ACT_SPECIAL,12'h000,3'h0,12'h068);
    tc(8'h06,RX_NONE,3'h0,ACT_INSERT,12'h123,3'h5,12'h068);
    tc(8'h06,RX_NONE,3'h2,ACT_PASS,12'h000,3'h0,12'h064);
    tc(8'h06,RX_NONE,3'h5,ACT_INSERT,12'h123,3'h5,12'h068);
    tc(8'h22,RX_PRIO,3'h0,ACT_MODIFY,12'h123,3'h5,12'h064);
    tc(8'h02,RX_PRIO,3'h2,ACT_STRIP,12'h000,3'h0,12'h060);
    tc(8'h3A,RX_NORMAL,3'h0,ACT_MODIFY,12'h456,3'h3,12'h064);
    tc(8'h12,RX_NORMAL,3'h0,ACT_PASS,12'h000,3'h0,12'h064);
    tc(8'h3A,RX_NORMAL,3'h2,ACT_STRIP,12'h000,3'h0,12'h060);
    tc(8'h00,RX_NONE,3'h0,ACT_PASS,12'h000,3'h0,12'h064);
    tc(8'h01,RX_NONE,3'h0,ACT_PASS,12'h000,3'h0,12'h064);
    tc(8'h01,RX_SPECIAL,3'h0,ACT_STRIP,12'h000,3'h0,12'h060);
    tc(8'h03,RX_SPECIAL,3'h0,ACT_SPECIAL,12'h000,3'h0,12'h064);
    tc(8'h02,RX_SPECIAL,3'h0,ACT_STRIP,12'h000,3'h0,12'h060);
    tc(8'h02,RX_PRIO,3'h0,ACT_MODIFY,12'h123,3'h2,12'h064);
    tc(8'h0A,RX_NORMAL,3'h0,ACT_PASS,12'h000,3'h0,12'h064);
    tc(8'h1A,RX_NORMAL,3'h0,ACT_MODIFY,12'h456,3'h2,12'h064);
    $display("test tags done");
    lat <= 4'h3;
    wr(OFS_RATE_EN, 32'h00000080);
    wr(OFS_RATE0 + 8'h1C, 32'h0);
    bdesc  <= '{11'h00A, RX_NONE, 2'h1, 12'h0AB, 3'h2, 3'h0};
    q_pend <= 12'h090;
    grant(4'h7);
    t0 = cyc;
    grant(4'h4);
    @(posedge clk);
    q_pend[4] <= 1'b0;
    rd(OFS_STATUS, rv);
    chk(rv[7], 1'b1, "held");
    // 10 bytes at the minimum step of 20 cycles a byte
    grant(4'h7);
    chk((cyc - t0) >= 198 && (cyc - t0) <= 206, 1'b1, "gap");
    @(posedge clk);
    q_pend[7] <= 1'b0;
    repeat (250) @(posedge clk);
    wr(OFS_RATE_EN, 32'h00020080);
    wr(OFS_RATE0 + 8'h1C, 32'h28);
    q_pend[7] <= 1'b1;
    grant(4'h7);
    t0 = cyc;
    grant(4'h7);
    chk((cyc - t0) < 40, 1'b1, "bypass");
    @(posedge clk);
    q_pend <= 12'h000;
    // setting 4 is 100 ns a byte: 10 bytes hold the queue 250 cycles
    wr(OFS_RATE0 + 8'h1C, 32'h4);
    q_pend[7] <= 1'b1;
    grant(4'h7);
    t0 = cyc;
    grant(4'h7);
    chk((cyc - t0) >= 248 && (cyc - t0) <= 256, 1'b1, "step");
    @(posedge clk);
    q_pend <= 12'h000;
    $display("test limiter done");
    final_report;
  end
endmodule
